// *** logic/trqa_params.svh ***
// Purpose: constants of the queue arbiter
// Assumes: queue depths are powers of two
// Notes: sizes are in elements, counts in entries
`ifndef TRQA_PARAMS_SVH
`define TRQA_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// allotments per requestor in the high and low queues
`define TRQA_IMM_ALLOT 2'h3
`define TRQA_CHN_ALLOT 4'h8

// queue depths; urgent one equals the cache maximum
`define TRQA_URG_DEPTH 4
`define TRQA_HIGH_DEPTH 16
`define TRQA_LOW_DEPTH 16
`define TRQA_CNT_W 5

////////////////////////////////////////////////////////////////////////////////
// counts and widths
`define TRQA_N_CH 16
`define TRQA_N_RES 4
`define TRQA_N_LVL 3
`define TRQA_DATA_W 32
`define TRQA_LEN_W 8
`define TRQA_BLEN_W 5

////////////////////////////////////////////////////////////////////////////////
// burst size bounds and per-resource burst sizes, read and write direction
`define TRQA_BURST_MIN 5'h01
`define TRQA_BURST_MAX 5'h10
`define TRQA_RD_SZ_0 5'h10
`define TRQA_RD_SZ_1 5'h10
`define TRQA_RD_SZ_2 5'h01
`define TRQA_RD_SZ_3 5'h08
`define TRQA_WR_SZ_0 5'h10
`define TRQA_WR_SZ_1 5'h08
`define TRQA_WR_SZ_2 5'h01
`define TRQA_WR_SZ_3 5'h08

`endif

// *** logic/trqa_pkg.sv ***
// Purpose: types of the queue arbiter
// Assumes: constants come from the params header
// Notes: entry is what each queue slot holds
`include "trqa_params.svh"

package trqa_pkg;
   // who submitted an entry
   typedef enum logic [1:0] {REQ_CACHE, REQ_IMM, REQ_CHAN, REQ_HOST} trqa_req_t;
   // levels, index order urgent, high, low
   typedef enum logic [1:0] {LVL_URG, LVL_HIGH, LVL_LOW} trqa_lvl_t;
   typedef logic [1:0] trqa_res_t;
   typedef logic [`TRQA_LEN_W-1:0] trqa_len_t;
   typedef logic [`TRQA_BLEN_W-1:0] trqa_blen_t;
   typedef logic [`TRQA_DATA_W-1:0] trqa_data_t;
   typedef logic [`TRQA_CNT_W-1:0] trqa_cnt_t;
   // one queued transfer request
   typedef struct packed {
      trqa_req_t req;
      trqa_res_t src;
      trqa_res_t dst;
      trqa_len_t len;
   } trqa_entry_t;
endpackage : trqa_pkg

// *** logic/trqa_fifo.sv ***
// Purpose: in-order queue of request entries
// Assumes: DEPTH a power of two; no push when full, no pop when empty
// Notes: storage is flip-flops indexed by wrapping pointers
`timescale 1ns/1ns
`default_nettype none

module trqa_fifo
#(
   parameter int DEPTH = 16
)
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // write side
   input wire logic i_push,
   input wire trqa_pkg::trqa_entry_t i_data,
   // read side
   input wire logic i_pop,
   output trqa_pkg::trqa_entry_t o_data,
   output trqa_pkg::trqa_cnt_t o_count
);
   import trqa_pkg::*;

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      trqa_entry_t [DEPTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      trqa_cnt_t cnt;
   } trqa_fifo_st_t;

   trqa_fifo_st_t q;
   trqa_fifo_st_t d;

   ////////////////////////////////////////////////////////////////////////////////
   // pointers only move forward, so order out equals order in
   always_comb
   begin
      d = q;
      if (i_push)
      begin
         d.mem[q.wp] = i_data;
         d.wp = q.wp + 1'b1;
      end
      if (i_pop)
      begin
         d.rp = q.rp + 1'b1;
      end
      d.cnt = q.cnt + trqa_cnt_t'(i_push) - trqa_cnt_t'(i_pop);
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign o_data = q.mem[q.rp];
   assign o_count = q.cnt;
endmodule : trqa_fifo

`default_nettype wire

// *** logic/trqa_active.sv ***
// Purpose: active register set of one priority level
// Assumes: loaded only while idle and resources free
// Notes: splits the entry into bursts of 1 to 16
`timescale 1ns/1ns
`default_nettype none

module trqa_active
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // load from the priority queue head
   input wire logic i_load,
   input wire trqa_pkg::trqa_entry_t i_entry,
   // one element taken from the read bus
   input wire logic i_take,
   // status toward the top
   output logic o_idle,
   output logic o_moving,
   output trqa_pkg::trqa_blen_t o_left,
   output trqa_pkg::trqa_res_t o_src,
   output trqa_pkg::trqa_res_t o_dst,
   // burst request to resources
   output logic o_breq,
   output trqa_pkg::trqa_blen_t o_blen
);
   import trqa_pkg::*;

   typedef enum logic [1:0] {ACT_IDLE, ACT_ISSUE, ACT_MOVE} trqa_act_state_t;

   typedef struct packed {
      trqa_act_state_t st;
      trqa_entry_t ent;
      logic [`TRQA_LEN_W:0] remain;
      trqa_blen_t beats;
      trqa_blen_t blen;
      logic breq;
   } trqa_act_st_t;

   trqa_act_st_t q;
   trqa_act_st_t d;

   // burst size per resource, read direction
   function automatic trqa_blen_t rd_size(input trqa_res_t r);
      case (r)
         2'h0: rd_size = `TRQA_RD_SZ_0;
         2'h1: rd_size = `TRQA_RD_SZ_1;
         2'h2: rd_size = `TRQA_RD_SZ_2;
         default: rd_size = `TRQA_RD_SZ_3;
      endcase
   endfunction : rd_size

   // burst size per resource, write direction
   function automatic trqa_blen_t wr_size(input trqa_res_t r);
      case (r)
         2'h0: wr_size = `TRQA_WR_SZ_0;
         2'h1: wr_size = `TRQA_WR_SZ_1;
         2'h2: wr_size = `TRQA_WR_SZ_2;
         default: wr_size = `TRQA_WR_SZ_3;
      endcase
   endfunction : wr_size

   ////////////////////////////////////////////////////////////////////////////////
   // one entry at a time: load, issue burst, move its elements, repeat
   always_comb
   begin
      trqa_blen_t lim;
      lim = rd_size(q.ent.src);
      d = q;
      d.breq = 1'b0;
      if (wr_size(q.ent.dst) < lim)
      begin
         lim = wr_size(q.ent.dst); // smaller of read and write sizes [RQ12]
      end
      case (q.st)
         ACT_IDLE:
         begin
            if (i_load)
            begin
               d.ent = i_entry; // single entry held [RQ11]
               d.remain = (i_entry.len == '0) ? 9'h001 : {1'b0, i_entry.len};
               d.st = ACT_ISSUE;
            end
         end
         ACT_ISSUE:
         begin
            // a short tail sends fewer elements, never below one
            if (q.remain < {4'h0, lim})
            begin
               d.blen = q.remain[`TRQA_BLEN_W-1:0]; // [RQ12]
            end
            else
            begin
               d.blen = lim; // [RQ12]
            end
            d.beats = d.blen;
            d.breq = 1'b1;
            d.st = ACT_MOVE;
         end
         ACT_MOVE:
         begin
            if (i_take)
            begin
               d.beats = q.beats - 1'b1;
               if (q.beats == `TRQA_BURST_MIN)
               begin
                  d.remain = q.remain - {4'h0, q.blen};
                  d.st = (d.remain == '0) ? ACT_IDLE : ACT_ISSUE;
               end
            end
         end
         default:
         begin
            d.st = ACT_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign o_idle = (q.st == ACT_IDLE);
   assign o_moving = (q.st == ACT_MOVE);
   assign o_left = q.beats;
   assign o_src = q.ent.src;
   assign o_dst = q.ent.dst;
   assign o_breq = q.breq;
   assign o_blen = q.blen;
endmodule : trqa_active

`default_nettype wire

// *** logic/trqa_top.sv ***
// Purpose: request queueing and arbitration of a DMA engine
// Assumes: all inputs synchronous to I_CLOCK; resources honour read ready
// Notes: one push per queue per cycle; host wins the high queue slot
`timescale 1ns/1ns
`default_nettype none

// Operation
// [RQ1] high/low queues: immediate 3, channel 8 outstanding
// [RQ2] allotment count excludes entry in active set
// [RQ3] urgent queue unlimited, sized for cache maximum
// [RQ4] full allotment holds next request back
// [RQ5] held immediate request stalls processor until accepted
// [RQ6] held channel request blocks both levels
// [RQ7] channel resumes when its queued entry advances
// [RQ8] sync events latched during stall; repeats merge
// [RQ9] each level served first in, first out
// [RQ10] every level has its own active set
// [RQ11] active set holds one request at most
// [RQ12] bursts of 1 to 16, per resource/direction
// [RQ13] levels run concurrently with bursts outstanding
// [RQ14] each resource has own read bus
// [RQ15] one shared write bus; peripherals buffer bursts
// [RQ16] levels move data together only on different resources
// [RQ17] software places urgent small work on high
// [RQ18] cache and host levels fixed
// [RQ19] host requests always go to high queue
// [RQ20] each immediate write submits exactly one request
// [RQ21] allotment counters: up on accept, down on advance
module trqa_top
(
   // clock and reset
   input wire logic I_CLOCK,
   input wire logic I_SRST,
   // cache controller requests, urgent level
   input wire logic I_CC_VALID,
   input wire trqa_pkg::trqa_res_t I_CC_SRC,
   input wire trqa_pkg::trqa_res_t I_CC_DST,
   input wire trqa_pkg::trqa_len_t I_CC_LEN,
   output logic O_CC_READY,
   // host port requests, high level
   input wire logic I_HOST_VALID,
   input wire trqa_pkg::trqa_res_t I_HOST_SRC,
   input wire trqa_pkg::trqa_res_t I_HOST_DST,
   input wire trqa_pkg::trqa_len_t I_HOST_LEN,
   output logic O_HOST_READY,
   // immediate transfer path pseudo-register write
   input wire logic I_IMM_WR,
   input wire logic I_IMM_LOW,
   input wire trqa_pkg::trqa_res_t I_IMM_SRC,
   input wire trqa_pkg::trqa_res_t I_IMM_DST,
   input wire trqa_pkg::trqa_len_t I_IMM_LEN,
   output logic O_CPU_STALL,
   // channel transfer engine events and per-channel setup
   input wire logic [`TRQA_N_CH-1:0] I_SYNC_EVT,
   input wire logic [`TRQA_N_CH-1:0] I_CH_LOW,
   input wire trqa_pkg::trqa_res_t [`TRQA_N_CH-1:0] I_CH_SRC,
   input wire trqa_pkg::trqa_res_t [`TRQA_N_CH-1:0] I_CH_DST,
   input wire trqa_pkg::trqa_len_t [`TRQA_N_CH-1:0] I_CH_LEN,
   output logic O_CHN_STALL,
   output logic [`TRQA_N_CH-1:0] O_EVT_PEND,
   // burst requests, one lane per level
   output logic [`TRQA_N_LVL-1:0] O_BREQ_VALID,
   output trqa_pkg::trqa_res_t [`TRQA_N_LVL-1:0] O_BREQ_SRC,
   output trqa_pkg::trqa_res_t [`TRQA_N_LVL-1:0] O_BREQ_DST,
   output trqa_pkg::trqa_blen_t [`TRQA_N_LVL-1:0] O_BREQ_LEN,
   // dedicated read buses
   input wire logic [`TRQA_N_RES-1:0] I_RD_VALID,
   input wire trqa_pkg::trqa_data_t [`TRQA_N_RES-1:0] I_RD_DATA,
   output logic [`TRQA_N_RES-1:0] O_RD_READY,
   // shared write bus
   output logic O_WR_VALID,
   output trqa_pkg::trqa_res_t O_WR_SEL,
   output trqa_pkg::trqa_data_t O_WR_DATA
);
   import trqa_pkg::*;

   typedef struct packed {
      logic [1:0][1:0] imm_cnt;
      logic [1:0][3:0] chn_cnt;
      logic imm_pend;
      logic imm_low;
      trqa_entry_t imm_ent;
      logic [`TRQA_N_CH-1:0] evt;
      logic hold;
      logic [3:0] hold_ch;
      logic cc_rdy;
      logic host_rdy;
      logic cpu_stall;
      logic chn_stall;
      logic [`TRQA_N_RES-1:0] rd_rdy;
      logic [1:0] gnt;
      logic wr_vld;
      trqa_res_t wr_sel;
      trqa_data_t wr_data;
   } trqa_top_st_t;

   trqa_top_st_t q;
   trqa_top_st_t d;

   // queue and active set interconnect, indexed by level
   logic [`TRQA_N_LVL-1:0] push;
   logic [`TRQA_N_LVL-1:0] pop;
   trqa_entry_t [`TRQA_N_LVL-1:0] push_ent;
   trqa_entry_t [`TRQA_N_LVL-1:0] head;
   trqa_cnt_t [`TRQA_N_LVL-1:0] qcnt;
   logic [`TRQA_N_LVL-1:0] act_idle;
   logic [`TRQA_N_LVL-1:0] act_moving;
   logic [`TRQA_N_LVL-1:0] take;
   trqa_blen_t [`TRQA_N_LVL-1:0] act_left;
   trqa_res_t [`TRQA_N_LVL-1:0] act_src;
   trqa_res_t [`TRQA_N_LVL-1:0] act_dst;
   trqa_cnt_t [`TRQA_N_LVL-1:0] depth;

   assign depth[0] = trqa_cnt_t'(`TRQA_URG_DEPTH);
   assign depth[1] = trqa_cnt_t'(`TRQA_HIGH_DEPTH);
   assign depth[2] = trqa_cnt_t'(`TRQA_LOW_DEPTH);

   ////////////////////////////////////////////////////////////////////////////////
   // one queue and one active set per level
   genvar g;
   generate
      for (g = 0; g < `TRQA_N_LVL; g++)
      begin : gen_lvl
         localparam int DEP = (g == 0) ? `TRQA_URG_DEPTH : (g == 1) ? `TRQA_HIGH_DEPTH : `TRQA_LOW_DEPTH;
         trqa_fifo #(.DEPTH(DEP)) u_queue // strict arrival order [RQ9]
         (
            .i_clk(I_CLOCK),
            .i_srst(I_SRST),
            .i_push(push[g]),
            .i_data(push_ent[g]),
            .i_pop(pop[g]),
            .o_data(head[g]),
            .o_count(qcnt[g])
         );
         trqa_active u_active // independent set per level [RQ10]
         (
            .i_clk(I_CLOCK),
            .i_srst(I_SRST),
            .i_load(pop[g]),
            .i_entry(head[g]),
            .i_take(take[g]),
            .o_idle(act_idle[g]),
            .o_moving(act_moving[g]),
            .o_left(act_left[g]),
            .o_src(act_src[g]),
            .o_dst(act_dst[g]),
            .o_breq(O_BREQ_VALID[g]), // levels issue bursts concurrently [RQ13]
            .o_blen(O_BREQ_LEN[g])
         );
         assign O_BREQ_SRC[g] = act_src[g];
         assign O_BREQ_DST[g] = act_dst[g];
         // only the granted level takes a beat from its source
         assign take[g] = act_moving[g] && (q.gnt == 2'(g)) && q.rd_rdy[act_src[g]]
                          && I_RD_VALID[act_src[g]]; // [RQ14]
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // advance heads into idle sets, never onto a busy resource
   always_comb
   begin
      trqa_res_t cs;
      trqa_res_t cd;
      cs = '0;
      cd = '0;
      pop = '0;
      for (int l = 0; l < `TRQA_N_LVL; l++)
      begin
         if (qcnt[l] != '0 && act_idle[l])
         begin
            pop[l] = 1'b1;
            for (int k = 0; k < `TRQA_N_LVL; k++)
            begin
               cs = act_idle[k] ? head[k].src : act_src[k];
               cd = act_idle[k] ? head[k].dst : act_dst[k];
               // lower-index level already claiming wins a same-cycle tie
               if (k != l && (!act_idle[k] || pop[k]) &&
                   (cs == head[l].src || cs == head[l].dst || cd == head[l].src || cd == head[l].dst))
               begin
                  pop[l] = 1'b0; // disjoint resources only [RQ16]
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // submission, allotments, stalls and data routing
   always_comb
   begin
      logic imm_v;
      logic imm_lo;
      trqa_entry_t imm_e;
      logic imm_ok;
      logic ch_v;
      logic [3:0] ch;
      logic ch_lo;
      trqa_entry_t ch_e;
      logic ch_ok;
      logic ch_room;
      logic found;
      logic [1:0] lv;
      trqa_cnt_t nxt;
      imm_v = 1'b0;
      imm_lo = 1'b0;
      imm_e = '0;
      imm_ok = 1'b0;
      ch_v = 1'b0;
      ch = '0;
      ch_lo = 1'b0;
      ch_e = '0;
      ch_ok = 1'b0;
      ch_room = 1'b0;
      found = 1'b0;
      lv = '0;
      nxt = '0;
      d = q;
      push = '0;
      push_ent = '0;

      // cache controller only ever uses the urgent queue
      push[LVL_URG] = I_CC_VALID && q.cc_rdy; // fixed level [RQ18]
      push_ent[LVL_URG] = '{REQ_CACHE, I_CC_SRC, I_CC_DST, I_CC_LEN}; // no allotment [RQ3]

      // host port always lands in the high queue and takes its slot first
      push[LVL_HIGH] = I_HOST_VALID && q.host_rdy; // [RQ19] [RQ18]
      push_ent[LVL_HIGH] = '{REQ_HOST, I_HOST_SRC, I_HOST_DST, I_HOST_LEN};

      // immediate path: a held request goes before any new write
      if (q.imm_pend)
      begin
         imm_v = 1'b1;
         imm_lo = q.imm_low;
         imm_e = q.imm_ent;
      end
      else if (I_IMM_WR)
      begin
         imm_v = 1'b1; // one write, one request [RQ20]
         imm_lo = I_IMM_LOW;
         imm_e = '{REQ_IMM, I_IMM_SRC, I_IMM_DST, I_IMM_LEN};
      end
      imm_ok = imm_v && (q.imm_cnt[imm_lo] < `TRQA_IMM_ALLOT) // [RQ1] [RQ4]
               && (qcnt[imm_lo ? 2 : 1] < depth[imm_lo ? 2 : 1]) && !(!imm_lo && push[LVL_HIGH]);
      if (imm_ok)
      begin
         push[imm_lo ? 2 : 1] = 1'b1;
         push_ent[imm_lo ? 2 : 1] = imm_e;
      end
      // a refused write waits here with the processor stalled
      d.imm_pend = imm_v && !imm_ok; // [RQ5]
      d.imm_low = imm_lo;
      d.imm_ent = imm_e;
      d.cpu_stall = d.imm_pend; // released once it enters its queue [RQ5]

      // channel engine: a held channel blocks every other one [RQ6]
      if (q.hold)
      begin
         ch_v = 1'b1;
         ch = q.hold_ch;
      end
      else
      begin
         for (int i = `TRQA_N_CH - 1; i >= 0; i--)
         begin
            if (q.evt[i])
            begin
               ch_v = 1'b1;
               ch = 4'(i);
            end
         end
      end
      ch_lo = I_CH_LOW[ch];
      ch_e = '{REQ_CHAN, I_CH_SRC[ch], I_CH_DST[ch], I_CH_LEN[ch]};
      ch_room = (q.chn_cnt[ch_lo] < `TRQA_CHN_ALLOT) // [RQ1] [RQ4]
                && (qcnt[ch_lo ? 2 : 1] < depth[ch_lo ? 2 : 1]);
      ch_ok = ch_v && ch_room && !push[ch_lo ? 2 : 1];
      if (ch_ok)
      begin
         push[ch_lo ? 2 : 1] = 1'b1;
         push_ent[ch_lo ? 2 : 1] = ch_e;
      end
      // losing the slot to another submitter is a retry, not a stall
      d.hold = ch_v && !ch_room; // resumes when its entry advances [RQ7]
      d.hold_ch = ch;
      d.chn_stall = d.hold; // [RQ6]

      // events keep latching during a stall; a repeat merges into its bit
      d.evt = (q.evt & ~(ch_ok ? (`TRQA_N_CH'(1) << ch) : '0)) | I_SYNC_EVT; // set wins [RQ8]

      // allotments count queued entries only, so they drop on advance
      for (int l = 0; l < 2; l++)
      begin
         d.imm_cnt[l] = q.imm_cnt[l] // [RQ21] [RQ2]
                        + 2'(push[l + 1] && push_ent[l + 1].req == REQ_IMM)
                        - 2'(pop[l + 1] && head[l + 1].req == REQ_IMM);
         d.chn_cnt[l] = q.chn_cnt[l] // [RQ21] [RQ2]
                        + 4'(push[l + 1] && push_ent[l + 1].req == REQ_CHAN)
                        - 4'(pop[l + 1] && head[l + 1].req == REQ_CHAN);
      end

      // ready for next cycle from the occupancy this cycle leaves behind
      nxt = qcnt[0] + trqa_cnt_t'(push[0]) - trqa_cnt_t'(pop[0]);
      d.cc_rdy = nxt < depth[0]; // [RQ3]
      nxt = qcnt[1] + trqa_cnt_t'(push[1]) - trqa_cnt_t'(pop[1]);
      d.host_rdy = nxt < depth[1];

      // rotate the write bus among levels that still expect beats
      d.rd_rdy = '0;
      for (int i = 1; i <= `TRQA_N_LVL; i++)
      begin
         lv = 2'((int'(q.gnt) + i) % `TRQA_N_LVL);
         if (!found && act_moving[lv] && (act_left[lv] - trqa_blen_t'(take[lv])) != '0)
         begin
            found = 1'b1;
            d.gnt = lv;
            d.rd_rdy[act_src[lv]] = 1'b1; // [RQ14]
         end
      end

      // a taken read beat goes onto the one write bus the next cycle
      d.wr_vld = |take; // [RQ15]
      for (int l = 0; l < `TRQA_N_LVL; l++)
      begin
         if (take[l])
         begin
            d.wr_sel = act_dst[l]; // [RQ15]
            d.wr_data = I_RD_DATA[act_src[l]];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge I_CLOCK)
   begin
      if (I_SRST)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs straight from state flops
   assign O_CC_READY = q.cc_rdy;
   assign O_HOST_READY = q.host_rdy;
   assign O_CPU_STALL = q.cpu_stall;
   assign O_CHN_STALL = q.chn_stall;
   assign O_EVT_PEND = q.evt;
   assign O_RD_READY = q.rd_rdy;
   assign O_WR_VALID = q.wr_vld;
   assign O_WR_SEL = q.wr_sel;
   assign O_WR_DATA = q.wr_data;
endmodule : trqa_top

`default_nettype wire

// *** dv/trqa_monitor.sv ***
// Purpose: port checker of the arbiter
// Assumes: one clock, sync reset
// Notes: bound into trqa_top below
`timescale 1ns/1ns
`default_nettype none
`include "trqa_params.svh"

module trqa_mon
(
   // clock and reset
   input wire logic I_CLOCK,
   input wire logic I_SRST,
   // request side
   input wire logic I_IMM_WR,
   input wire logic [`TRQA_N_CH-1:0] I_SYNC_EVT,
   input wire logic O_CPU_STALL,
   input wire logic O_CHN_STALL,
   input wire logic [`TRQA_N_CH-1:0] O_EVT_PEND,
   // resource side
   input wire logic [`TRQA_N_LVL-1:0] O_BREQ_VALID,
   input wire trqa_pkg::trqa_blen_t [`TRQA_N_LVL-1:0] O_BREQ_LEN,
   input wire logic [`TRQA_N_RES-1:0] I_RD_VALID,
   input wire logic [`TRQA_N_RES-1:0] O_RD_READY,
   input wire logic O_WR_VALID
);
   import trqa_pkg::*;
   // one domain
   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (I_SRST);
   ////////////////////////////////////////
   a_len_high: assert property (O_BREQ_VALID[1] |-> O_BREQ_LEN[1] inside {[5'h01:5'h10]})
      else $error("burst length out of range");
   a_burst_once: assert property (O_BREQ_VALID[0] |=> !O_BREQ_VALID[0])
      else $error("burst repeated");
   a_read_onehot: assert property ($onehot0(O_RD_READY))
      else $error("two read buses granted");
   a_beat_forward: assert property ((|(I_RD_VALID & O_RD_READY)) |=> O_WR_VALID)
      else $error("beat not forwarded");
   a_write_cause: assert property (O_WR_VALID |-> $past(|(I_RD_VALID & O_RD_READY)))
      else $error("write without read beat");
   a_event_kept: assert property ((|I_SYNC_EVT) |=> (O_EVT_PEND & $past(I_SYNC_EVT)) == $past(I_SYNC_EVT))
      else $error("sync event lost");
   a_cpu_stall_cause: assert property ($rose(O_CPU_STALL) |-> $past(I_IMM_WR))
      else $error("stall without write");
   a_chn_stall_cause: assert property ($rose(O_CHN_STALL) |-> $past(|O_EVT_PEND))
      else $error("stall without event");
endmodule : trqa_mon

bind trqa_top trqa_mon u_trqa_mon
(
   .I_CLOCK(I_CLOCK), .I_SRST(I_SRST), .I_IMM_WR(I_IMM_WR), .I_SYNC_EVT(I_SYNC_EVT), .O_CPU_STALL(O_CPU_STALL),
   .O_CHN_STALL(O_CHN_STALL), .O_EVT_PEND(O_EVT_PEND), .O_BREQ_VALID(O_BREQ_VALID), .O_BREQ_LEN(O_BREQ_LEN),
   .I_RD_VALID(I_RD_VALID), .O_RD_READY(O_RD_READY), .O_WR_VALID(O_WR_VALID)
);
`default_nettype wire

// *** dv/trqa_res_model.sv ***
// Purpose: resources behind the read buses
// Assumes: ready sampled on the same edge
// Notes: i_hold starves every bus
`timescale 1ns/1ns
`default_nettype none
`include "trqa_params.svh"

module trqa_res_model
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // starve every read bus while high
   input wire logic i_hold,
   // dedicated read buses
   input wire logic [`TRQA_N_RES-1:0] i_rd_ready,
   output logic [`TRQA_N_RES-1:0] o_rd_valid,
   output trqa_pkg::trqa_data_t [`TRQA_N_RES-1:0] o_rd_data
);
   import trqa_pkg::*;
   logic ph_q;
   // slow phase
   always_ff @(posedge i_clk)
      ph_q <= !ph_q && !i_srst;
   // 0,1 every cycle, 2,3 every other; idle shows inverse
   always_comb
   begin
      for (int r = 0; r < 4; r++)
      begin
         o_rd_valid[r] = !i_hold && !i_srst && (r < 2 || ph_q);
         o_rd_data[r] = {8'h5A, 22'h00_0000, 2'(r)};
         if (!o_rd_valid[r])
            o_rd_data[r] = ~o_rd_data[r];
      end
   end
endmodule : trqa_res_model
`default_nettype wire

// *** dv/testbench.sv ***
// Purpose: bench of the queue arbiter
// Assumes: model drives read buses
// Notes: hold starves reads so queues fill
`timescale 1ns/1ns
`default_nettype none
`include "trqa_params.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end

module testbench;
   import trqa_pkg::*;
   int n_errors = 0;
   int checks_done = 0;
   int n_wr = 0;
   logic clk = 1'b0, srst = 1'b1, hold = 1'b0, cc_v = 1'b0, host_v = 1'b0, imm_wr = 1'b0, imm_low = 1'b0;
   logic cc_rdy, host_rdy, cpu_stall, chn_stall, wr_v;
   logic [2:0] breq_v;
   logic [2:0] seen = 3'h0;
   logic [3:0] rd_v, rd_rdy;
   logic [15:0] evt = 16'h0000;
   logic [15:0] pend;
   trqa_res_t src = 2'h0, dst = 2'h0;
   trqa_len_t len = 8'h01;
   trqa_data_t [3:0] rd_data;
   trqa_data_t wr_dat;
   // ch 0..9 low, res 1 to 3; ch 10 high, res 0 to 1
   trqa_res_t [15:0] ch_src = {{6{2'h0}}, {10{2'h1}}};
   trqa_res_t [15:0] ch_dst = {{6{2'h1}}, {10{2'h3}}};
   trqa_len_t [15:0] ch_len = {16{8'h01}};

   trqa_top u_trqa_top
   (
      .I_CLOCK(clk), .I_SRST(srst), .I_CC_VALID(cc_v), .I_CC_SRC(src), .I_CC_DST(dst), .I_CC_LEN(len),
      .O_CC_READY(cc_rdy), .I_HOST_VALID(host_v), .I_HOST_SRC(src), .I_HOST_DST(dst), .I_HOST_LEN(len),
      .O_HOST_READY(host_rdy), .I_IMM_WR(imm_wr), .I_IMM_LOW(imm_low), .I_IMM_SRC(src), .I_IMM_DST(dst),
      .I_IMM_LEN(len), .O_CPU_STALL(cpu_stall), .I_SYNC_EVT(evt), .I_CH_LOW(16'h03FF), .I_CH_SRC(ch_src),
      .I_CH_DST(ch_dst), .I_CH_LEN(ch_len), .O_CHN_STALL(chn_stall), .O_EVT_PEND(pend), .O_BREQ_VALID(breq_v),
      .O_BREQ_SRC(), .O_BREQ_DST(), .O_BREQ_LEN(), .I_RD_VALID(rd_v), .I_RD_DATA(rd_data), .O_RD_READY(rd_rdy),
      .O_WR_VALID(wr_v), .O_WR_SEL(), .O_WR_DATA(wr_dat)
   );
   trqa_res_model u_trqa_res_model
   (
      .i_clk(clk), .i_srst(srst), .i_hold(hold), .i_rd_ready(rd_rdy), .o_rd_valid(rd_v), .o_rd_data(rd_data)
   );

   always #5 clk = ~clk;
   // tally write beats and burst lanes
   always @(posedge clk)
   begin
      if (wr_v === 1'b1)
         `CHK("write data tag", 8'h5A, wr_dat[31:24])
      n_wr <= n_wr + int'(wr_v === 1'b1);
      seen <= seen | breq_v;
   end
   ////////////////////////////////////////
   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : close_out

   // bounded wait; a shortfall ends the run
   task automatic wait_wr(input int n);
      for (int k = 0; k < 2000 && n_wr < n; k++)
         @(negedge clk);
      repeat (20) @(negedge clk);
      `CHK("elements written", n, n_wr)
      if (n_wr < n)
         close_out();
   endtask : wait_wr

   // kind 0 cache, 1 host, 2 immediate; valid held until ready, immediate write one cycle
   task automatic submit(input int kind, input trqa_res_t s, d, input trqa_len_t n, input logic low);
      @(posedge clk);
      {src, dst, len, imm_low} <= {s, d, n, low};
      {cc_v, host_v, imm_wr} <= {kind == 0, kind == 1, kind == 2};
      for (int k = 0; k < 200; k++)
      begin
         @(negedge clk);
         if (kind == 2 || (kind == 0 ? cc_rdy : host_rdy) === 1'b1)
         begin
            @(posedge clk);
            {cc_v, host_v, imm_wr} <= 3'h0;
            return;
         end
      end
      `CHK("request taken", 1'b1, 1'b0)
      close_out();
   endtask : submit

   task automatic pulse_evt(input logic [15:0] e);
      @(posedge clk);
      evt <= e;
      @(posedge clk);
      evt <= 16'h0000;
   endtask : pulse_evt

   // fixed or chosen levels; disjoint levels overlap
   task automatic t_levels();
      submit(0, 2'h0, 2'h1, 8'h03, 1'b0);
      wait_wr(3);
      submit(1, 2'h0, 2'h1, 8'h28, 1'b0);
      wait_wr(43);
      `CHK("cache and host lanes", 3'h3, seen)
      seen = 3'h0;
      submit(2, 2'h3, 2'h2, 8'h05, 1'b0);
      submit(2, 2'h1, 2'h0, 8'h0C, 1'b1);
      repeat (8) @(negedge clk);
      `CHK("both levels busy", 3'h6, seen)
      wait_wr(60);
   endtask : t_levels

   // starved: three queue, fifth write stalls
   task automatic t_imm_allot();
      @(posedge clk);
      hold <= 1'b1;
      for (int k = 0; k < 5; k++)
      begin
         submit(2, 2'h3, 2'h2, 8'h01, 1'b0);
         repeat (3) @(negedge clk);
         `CHK("processor stall", 1'(k == 4), cpu_stall)
      end
      @(posedge clk);
      hold <= 1'b0;
      wait_wr(65);
      `CHK("processor released", 1'b0, cpu_stall)
   endtask : t_imm_allot

   // refused channel blocks both levels; repeats merge
   task automatic t_chan_stall();
      @(posedge clk);
      hold <= 1'b1;
      pulse_evt(16'h0001);
      repeat (4) @(negedge clk);
      pulse_evt(16'h07FE);
      repeat (20) @(negedge clk);
      `CHK("channel stall", 1'b1, chn_stall)
      pulse_evt(16'h0400);
      pulse_evt(16'h0400);
      repeat (3) @(negedge clk);
      `CHK("held events", 16'h0600, pend)
      @(posedge clk);
      hold <= 1'b0;
      wait_wr(76);
      `CHK("channel released", 17'h0_0000, {chn_stall, pend})
   endtask : t_chan_stall

   initial
   begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      repeat (3) @(negedge clk);
      t_levels();
      t_imm_allot();
      t_chan_stall();
      close_out();
   end
endmodule : testbench
`default_nettype wire
